// ===== shared/irqf_cfg.svh
`ifndef IRQF_CFG_SVH
`define IRQF_CFG_SVH
// What this block does
// - Reading main interrupt register clears all its bits except bit 0.
// - Main bit 0 stays set until the auxiliary register is read or set-default clears it.
// - Main interrupt register is zero after power-up and set-default.
// - Auxiliary bits 7..0: deselect, framing, parity, CRC, FIFO, EE done, EE error, EE abort.
// - Parity or CRC errored frames still fill FIFO, flag raised too.
// - EEPROM error flag on write to protected word or missing address.
// - EEPROM done and error flags only for host-issued write commands.
// - Abort flag when host EEPROM access is cut by tag interface activity.
// - Reading auxiliary register returns flags, then clears it whole.
// - Auxiliary register is zero after power-up and set-default.
// - FIFO status 1 bits 5..0 give unread byte count; bits 7..6 zero.
// - Unread count stays within 0 to 32; zero means nothing to read.
// - FIFO status 1 cleared at power-up, set-default and clear command.
// - Underflow bit 6 of FIFO status 2 set when reading empty FIFO.
// - FIFO error flag on overflow or underflow; overflow shown in bit 5.
// - Incomplete last byte sets bit 4, valid bit count in bits 3..1.
// - Bit 0 of FIFO status 2 flags missing parity, counted as framing error.
// - Main bit 0 set whenever an auxiliary event is pending.
// - Auxiliary mask register at 09h suppresses signalling per event.

// Register addresses
`define IRQF_ADDR_W 6
`define IRQF_A_MAIN_MASK 6'h08
`define IRQF_A_AUX_MASK 6'h09
`define IRQF_A_MAIN 6'h0a
`define IRQF_A_AUX 6'h0b
`define IRQF_A_FIFO_ST1 6'h0c
`define IRQF_A_FIFO_ST2 6'h0d

// Reset values
`define IRQF_MAIN_MASK_RST 8'hc0
`define IRQF_AUX_MASK_RST 8'h00
`define IRQF_FLAGS_RST 8'h00

// Auxiliary flag positions
`define IRQF_AUX_DES 7
`define IRQF_AUX_FRAME 6
`define IRQF_AUX_PAR 5
`define IRQF_AUX_CRC 4
`define IRQF_AUX_FIFO 3
`define IRQF_AUX_EE_DONE 2
`define IRQF_AUX_EE_ERR 1
`define IRQF_AUX_EE_ABORT 0

// FIFO status 2 field positions
`define IRQF_ST2_UNF 6
`define IRQF_ST2_OVR 5
`define IRQF_ST2_NCP 4
`define IRQF_ST2_LB_MSB 3
`define IRQF_ST2_LB_LSB 1
`define IRQF_ST2_NPAR 0

// FIFO capacity in bytes
`define IRQF_FIFO_DEPTH 6'h20
`endif

// ===== shared/irqf_pkg.sv
package irqf_pkg;
  typedef logic [7:0] irqf_byte_type;
  typedef logic [5:0] irqf_count_type;
  typedef enum logic [2:0] {
    SEL_MAIN_MASK,
    SEL_AUX_MASK,
    SEL_MAIN,
    SEL_AUX,
    SEL_FIFO_ST1,
    SEL_FIFO_ST2,
    SEL_NONE
  } irqf_sel_type;
endpackage : irqf_pkg

// ===== core/irqf_fifo_track.sv
`timescale 1ns/10ps
`include "irqf_cfg.svh"
module irqf_fifo_track (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clear_in,
  // FIFO activity
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic frame_end_in,
  input wire logic [2:0] last_bits_in,
  input wire logic missing_parity_in,
  // Status
  output irqf_pkg::irqf_count_type count_out,
  output irqf_pkg::irqf_byte_type status2_out,
  output logic fifo_err_evt_out
);
  irqf_pkg::irqf_count_type count_q;
  logic unf_q;
  logic ovr_q;
  logic ncp_q;
  logic [2:0] lb_q;
  logic npar_q;
  logic push_ok;
  logic pop_ok;
  logic over;
  logic under;

  assign over = push_in && (count_q == `IRQF_FIFO_DEPTH);
  assign under = pop_in && (count_q == 6'h00);
  assign push_ok = push_in && !over;
  assign pop_ok = pop_in && !under;
  assign fifo_err_evt_out = over || under;

  // Count never passes the depth, so a full FIFO drops the byte
  always_ff @(posedge clk_in) begin
    if (rst_in || clear_in) begin
      count_q <= 6'h00;
    end else if (push_ok && !pop_ok) begin
      count_q <= count_q + 6'h01;
    end else if (pop_ok && !push_ok) begin
      count_q <= count_q - 6'h01;
    end
  end

  // Cause bits stay until the next clear
  always_ff @(posedge clk_in) begin
    if (rst_in || clear_in) begin
      unf_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      unf_q <= unf_q || under;
      ovr_q <= ovr_q || over;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || clear_in) begin
      ncp_q <= 1'b0;
      lb_q <= 3'h0;
      npar_q <= 1'b0;
    end else if (frame_end_in) begin
      ncp_q <= (last_bits_in != 3'h0);
      lb_q <= last_bits_in;
      npar_q <= missing_parity_in;
    end
  end

  assign count_out = count_q;
  assign status2_out = {1'b0, unf_q, ovr_q, ncp_q, lb_q, npar_q};

  a_count_range: assert property (@(posedge clk_in) disable iff (rst_in)
    count_q <= `IRQF_FIFO_DEPTH) else $error("unread count out of range");
  a_underflow_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    (pop_in && count_q == 6'h00 && !clear_in) |=>
      (unf_q && count_q == {5'h00, $past(push_in)}))
    else $error("underflow not recorded");
  a_overflow_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    (over && !clear_in) |-> fifo_err_evt_out ##1
      (ovr_q && count_q == `IRQF_FIFO_DEPTH - {5'h00, $past(pop_in)}))
    else $error("overflow not recorded");
endmodule : irqf_fifo_track

// ===== core/irqf_top.sv
`timescale 1ns/10ps
`include "irqf_cfg.svh"
module irqf_top (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // Direct commands
  input wire logic SET_DEFAULT_IN,
  input wire logic CLEAR_CMD_IN,
  // Register access from the serial host interface
  input wire logic REG_RD_IN,
  input wire logic REG_WR_IN,
  input wire logic [5:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  output logic [7:0] REG_RDATA_OUT,
  // Main interrupt events, bits 7 to 1
  input wire logic [7:1] MAIN_EVT_IN,
  // Tag framing events
  input wire logic DESELECT_EVT_IN,
  input wire logic FRAMING_EVT_IN,
  input wire logic PARITY_EVT_IN,
  input wire logic CRC_EVT_IN,
  // EEPROM controller events
  input wire logic EE_DONE_IN,
  input wire logic EE_WR_PROTECT_IN,
  input wire logic EE_BAD_ADDR_IN,
  input wire logic EE_FROM_HOST_IN,
  input wire logic EE_ABORT_IN,
  // FIFO activity
  input wire logic FIFO_PUSH_IN,
  input wire logic FIFO_POP_IN,
  input wire logic FRAME_END_IN,
  input wire logic [2:0] LAST_BITS_IN,
  input wire logic MISSING_PARITY_IN,
  // Interrupt to host
  output logic IRQ_OUT
);
  irqf_pkg::irqf_byte_type main_mask_q;
  irqf_pkg::irqf_byte_type aux_mask_q;
  irqf_pkg::irqf_byte_type main_q;
  irqf_pkg::irqf_byte_type aux_q;
  irqf_pkg::irqf_byte_type main_view;
  irqf_pkg::irqf_byte_type main_set;
  irqf_pkg::irqf_byte_type aux_set;
  irqf_pkg::irqf_byte_type status1;
  irqf_pkg::irqf_byte_type status2;
  irqf_pkg::irqf_byte_type rdata_q;
  irqf_pkg::irqf_count_type unread_count;
  irqf_pkg::irqf_sel_type sel;
  logic rd_main;
  logic rd_aux;
  logic fifo_err_evt;
  logic fifo_clear;
  logic ee_host_done;
  logic ee_fault;
  logic framing_evt;

  // Address decode
  always_comb begin
    case (REG_ADDR_IN)
      `IRQF_A_MAIN_MASK: begin
        sel = irqf_pkg::SEL_MAIN_MASK;
      end
      `IRQF_A_AUX_MASK: begin
        sel = irqf_pkg::SEL_AUX_MASK;
      end
      `IRQF_A_MAIN: begin
        sel = irqf_pkg::SEL_MAIN;
      end
      `IRQF_A_AUX: begin
        sel = irqf_pkg::SEL_AUX;
      end
      `IRQF_A_FIFO_ST1: begin
        sel = irqf_pkg::SEL_FIFO_ST1;
      end
      `IRQF_A_FIFO_ST2: begin
        sel = irqf_pkg::SEL_FIFO_ST2;
      end
      default: begin
        sel = irqf_pkg::SEL_NONE;
      end
    endcase
  end

  assign rd_main = REG_RD_IN && (sel == irqf_pkg::SEL_MAIN);
  assign rd_aux = REG_RD_IN && (sel == irqf_pkg::SEL_AUX);
  assign fifo_clear = SET_DEFAULT_IN || CLEAR_CMD_IN;

  // FIFO bookkeeping; byte storage lives elsewhere and is never gated by errors
  irqf_fifo_track u_fifo_track (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .clear_in(fifo_clear),
    .push_in(FIFO_PUSH_IN),
    .pop_in(FIFO_POP_IN),
    .frame_end_in(FRAME_END_IN),
    .last_bits_in(LAST_BITS_IN),
    .missing_parity_in(MISSING_PARITY_IN),
    .count_out(unread_count),
    .status2_out(status2),
    .fifo_err_evt_out(fifo_err_evt)
  );

  assign status1 = {2'b00, unread_count};

  // EEPROM outcomes only count for writes the host itself issued
  assign ee_fault = EE_WR_PROTECT_IN || EE_BAD_ADDR_IN;
  assign ee_host_done = EE_DONE_IN && EE_FROM_HOST_IN;
  // A frame whose last byte lacks parity is a framing error
  assign framing_evt = FRAMING_EVT_IN || (FRAME_END_IN && MISSING_PARITY_IN);

  always_comb begin
    aux_set = 8'h00;
    aux_set[`IRQF_AUX_DES] = DESELECT_EVT_IN;
    aux_set[`IRQF_AUX_FRAME] = framing_evt;
    aux_set[`IRQF_AUX_PAR] = PARITY_EVT_IN;
    aux_set[`IRQF_AUX_CRC] = CRC_EVT_IN;
    aux_set[`IRQF_AUX_FIFO] = fifo_err_evt;
    aux_set[`IRQF_AUX_EE_DONE] = ee_host_done && !ee_fault;
    aux_set[`IRQF_AUX_EE_ERR] = ee_host_done && ee_fault;
    aux_set[`IRQF_AUX_EE_ABORT] = EE_ABORT_IN && EE_FROM_HOST_IN;
  end

  assign main_set = {MAIN_EVT_IN, 1'b0};

  // Per-bit sticky flags; an event in the clearing cycle wins over the read
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
      always_ff @(posedge CLK_IN) begin
        if (RST_IN || SET_DEFAULT_IN) begin
          aux_q[gi] <= 1'b0;
        end else begin
          aux_q[gi] <= aux_set[gi] || (aux_q[gi] && !rd_aux);
        end
      end
      if (gi == 0) begin : g_summary
        // Summary bit is derived, so it falls only when the aux flags are read away or cleared by reset or set-default
        always_ff @(posedge CLK_IN) begin
          main_q[gi] <= 1'b0;
        end
      end else begin : g_main
        always_ff @(posedge CLK_IN) begin
          if (RST_IN || SET_DEFAULT_IN) begin
            main_q[gi] <= 1'b0;
          end else begin
            main_q[gi] <= main_set[gi] || (main_q[gi] && !rd_main);
          end
        end
      end
    end
  endgenerate

  assign main_view = {main_q[7:1], |aux_q};

  // Mask registers steer the interrupt output
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || SET_DEFAULT_IN) begin
      main_mask_q <= `IRQF_MAIN_MASK_RST;
      aux_mask_q <= `IRQF_AUX_MASK_RST;
    end else if (REG_WR_IN) begin
      if (sel == irqf_pkg::SEL_MAIN_MASK) begin
        main_mask_q <= {REG_WDATA_IN[7:1], 1'b0};
      end
      if (sel == irqf_pkg::SEL_AUX_MASK) begin
        aux_mask_q <= REG_WDATA_IN;
      end
    end
  end

  // Read data is captured at the strobe, before the clear takes effect
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      rdata_q <= 8'h00;
    end else if (REG_RD_IN) begin
      case (sel)
        irqf_pkg::SEL_MAIN_MASK: begin
          rdata_q <= main_mask_q;
        end
        irqf_pkg::SEL_AUX_MASK: begin
          rdata_q <= aux_mask_q;
        end
        irqf_pkg::SEL_MAIN: begin
          rdata_q <= main_view;
        end
        irqf_pkg::SEL_AUX: begin
          rdata_q <= aux_q;
        end
        irqf_pkg::SEL_FIFO_ST1: begin
          rdata_q <= status1;
        end
        irqf_pkg::SEL_FIFO_ST2: begin
          rdata_q <= status2;
        end
        default: begin
          rdata_q <= 8'h00;
        end
      endcase
    end
  end

  assign REG_RDATA_OUT = rdata_q;

  // Summary bit has no mask of its own; aux events are gated by their mask bits
  assign IRQ_OUT = (|(main_q[7:1] & ~main_mask_q[7:1])) ||
                   (|(aux_q & ~aux_mask_q));

  a_main_rd_clear: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (rd_main && MAIN_EVT_IN == 7'h00) |=> (main_view[7:1] == 7'h00))
    else $error("main flags survived a read");
  a_summary_hold: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (main_view[0] && !rd_aux && !SET_DEFAULT_IN) |=> main_view[0])
    else $error("summary bit dropped without aux read");
  a_main_default: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    SET_DEFAULT_IN |=> (main_view == 8'h00))
    else $error("main register not zero after default");
  a_aux_rd_clear: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (rd_aux && aux_set == 8'h00 && !SET_DEFAULT_IN) |=>
      (aux_q == 8'h00 && REG_RDATA_OUT == $past(aux_q)))
    else $error("aux read did not return and clear");
  a_aux_default: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    SET_DEFAULT_IN |=> (aux_q == 8'h00))
    else $error("aux register not zero after default");
  a_ee_host_only: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $rose(aux_q[`IRQF_AUX_EE_DONE] || aux_q[`IRQF_AUX_EE_ERR]) |->
      $past(EE_DONE_IN && EE_FROM_HOST_IN))
    else $error("EEPROM flag without host write");
  a_ee_fault_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (EE_DONE_IN && EE_FROM_HOST_IN && EE_WR_PROTECT_IN && !SET_DEFAULT_IN) |=>
      (aux_q[`IRQF_AUX_EE_ERR] && main_view[0]))
    else $error("protected write not flagged");
  a_parity_framing: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (FRAME_END_IN && MISSING_PARITY_IN && !fifo_clear) |=>
      (aux_q[`IRQF_AUX_FRAME] && status2[`IRQF_ST2_NPAR]))
    else $error("missing parity not seen as framing error");
  a_st1_clear: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    CLEAR_CMD_IN |=> (status1 == 8'h00))
    else $error("FIFO status 1 not cleared");
  a_mask_gate: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (main_q[7:1] == 7'h00 && (aux_q & ~aux_mask_q) == 8'h00) |-> !IRQ_OUT)
    else $error("masked event raised interrupt");

  // Flags only grow between reads, so an event never erases an older one
  a_main_sticky: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (!rd_main && !SET_DEFAULT_IN) |=>
      ((main_q[7:1] & $past(main_q[7:1])) == $past(main_q[7:1])))
    else $error("main flag lost without read");
  a_main_event: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (MAIN_EVT_IN != 7'h00 && !SET_DEFAULT_IN) |=>
      ((main_view[7:1] & $past(MAIN_EVT_IN)) == $past(MAIN_EVT_IN)))
    else $error("main event not latched");
  a_summary_set: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (aux_set != 8'h00 && !SET_DEFAULT_IN) |=> main_view[0])
    else $error("summary bit missing for aux event");
  a_summary_clear: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (rd_aux && aux_set == 8'h00 && !SET_DEFAULT_IN) |=> !main_view[0])
    else $error("summary bit kept after aux read");

  a_aux_sticky: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (!rd_aux && !SET_DEFAULT_IN) |=>
      ((aux_q & $past(aux_q)) == $past(aux_q)))
    else $error("aux flag lost without read");
  a_aux_event: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (aux_set != 8'h00 && !SET_DEFAULT_IN) |=>
      ((aux_q & $past(aux_set)) == $past(aux_set)))
    else $error("aux event not latched");
  a_deselect_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (DESELECT_EVT_IN && !SET_DEFAULT_IN) |=> aux_q[`IRQF_AUX_DES])
    else $error("deselect not flagged");
  // An errored byte still counts as stored, the error only adds a flag
  a_error_byte_kept: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (FIFO_PUSH_IN && !FIFO_POP_IN && (PARITY_EVT_IN || CRC_EVT_IN) && !fifo_clear &&
      unread_count != `IRQF_FIFO_DEPTH) |=> (unread_count == $past(unread_count) + 6'h01))
    else $error("errored byte not counted");
  a_fifo_err_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (fifo_err_evt && !SET_DEFAULT_IN) |=> aux_q[`IRQF_AUX_FIFO])
    else $error("FIFO error not flagged");
  a_ee_done_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (EE_DONE_IN && EE_FROM_HOST_IN && !ee_fault && !SET_DEFAULT_IN) |=> aux_q[`IRQF_AUX_EE_DONE])
    else $error("EEPROM done not flagged");
  a_bad_addr_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (EE_DONE_IN && EE_FROM_HOST_IN && EE_BAD_ADDR_IN && !SET_DEFAULT_IN) |=> aux_q[`IRQF_AUX_EE_ERR])
    else $error("bad address write not flagged");
  a_ee_abort_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (EE_ABORT_IN && EE_FROM_HOST_IN && !SET_DEFAULT_IN) |=> aux_q[`IRQF_AUX_EE_ABORT])
    else $error("EEPROM abort not flagged");

  a_st1_default: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    SET_DEFAULT_IN |=> (status1 == 8'h00))
    else $error("FIFO status 1 not cleared by default");
  a_rdata_hold: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !REG_RD_IN |=> $stable(REG_RDATA_OUT))
    else $error("read data changed without read");
  // Checked through the flag registers, so a broken flag path also trips it
  a_irq_raise: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    ((aux_set & ~aux_mask_q) != 8'h00 && !SET_DEFAULT_IN && !REG_WR_IN) |=> IRQ_OUT)
    else $error("unmasked aux event gave no interrupt");
  a_mask_default: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    SET_DEFAULT_IN |=> (main_mask_q == `IRQF_MAIN_MASK_RST && aux_mask_q == `IRQF_AUX_MASK_RST))
    else $error("mask registers not at default");
  a_aux_mask_write: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (REG_WR_IN && sel == irqf_pkg::SEL_AUX_MASK && !SET_DEFAULT_IN) |=> (aux_mask_q == $past(REG_WDATA_IN)))
    else $error("aux mask write lost");
  a_main_mask_write: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (REG_WR_IN && sel == irqf_pkg::SEL_MAIN_MASK && !SET_DEFAULT_IN) |=> (main_mask_q[0] == 1'b0))
    else $error("main mask bit 0 became writable");
endmodule : irqf_top

// ===== tb/irqf_host.sv
`timescale 1ns/10ps
module irqf_host (
  // Clock
  input wire logic clk_in,
  // Register strobes towards the device
  output logic rd_out,
  output logic wr_out,
  output logic [5:0] addr_out,
  output logic [7:0] wdata_out,
  // Read data from the device
  input wire logic [7:0] rdata_in
);
  initial begin
    rd_out = 1'b0;
    wr_out = 1'b0;
    addr_out = 6'h3f;
    wdata_out = 8'h00;
  end

  // Bus released lines show the inverse so a stale value is never mistaken for a live one
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk_in);
    rd_out = 1'b1;
    addr_out = a;
    @(negedge clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    @(negedge clk_in);
    d = rdata_in;
  endtask : rd

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask : wr
endmodule : irqf_host

// ===== tb/irq_and_fifo_status_regs_tb.sv
`timescale 1ns/10ps
module irq_and_fifo_status_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  // Event bits: 0 des,1 fr,2 par,3 crc,4 done,5 prot,6 bad,7 host,8 abort
  // 9 push,10 pop,11 frame end,12 no parity,13 clear,14 set default
  logic [14:0] ev = '0;
  logic [7:1] main_ev = '0;
  logic [2:0] last_bits = 3'h0;
  logic rd, wr, irq;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, got;
  int n_mismatch = 0;
  int n_checks = 0;

  always #4 clk = ~clk;

  irqf_top u_dut (
    .CLK_IN(clk), .RST_IN(rst), .SET_DEFAULT_IN(ev[14]), .CLEAR_CMD_IN(ev[13]),
    .REG_RD_IN(rd), .REG_WR_IN(wr), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_RDATA_OUT(rdata), .MAIN_EVT_IN(main_ev), .DESELECT_EVT_IN(ev[0]),
    .FRAMING_EVT_IN(ev[1]), .PARITY_EVT_IN(ev[2]), .CRC_EVT_IN(ev[3]),
    .EE_DONE_IN(ev[4]), .EE_WR_PROTECT_IN(ev[5]), .EE_BAD_ADDR_IN(ev[6]),
    .EE_FROM_HOST_IN(ev[7]), .EE_ABORT_IN(ev[8]), .FIFO_PUSH_IN(ev[9]),
    .FIFO_POP_IN(ev[10]), .FRAME_END_IN(ev[11]), .LAST_BITS_IN(last_bits),
    .MISSING_PARITY_IN(ev[12]), .IRQ_OUT(irq)
  );

  irqf_host u_host (
    .clk_in(clk), .rd_out(rd), .wr_out(wr), .addr_out(addr),
    .wdata_out(wdata), .rdata_in(rdata)
  );

  task automatic conclude;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic chk_irq(input logic e);
    chk({7'h00, irq}, {7'h00, e});
  endtask : chk_irq

  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    u_host.rd(a, got);
    chk(got, e);
  endtask : rc

  task automatic pulse(input logic [14:0] v);
    @(negedge clk) ev = v;
    @(negedge clk) ev = '0;
  endtask : pulse

  task automatic main_pulse(input logic [7:1] v);
    @(negedge clk) main_ev = v;
    @(negedge clk) main_ev = '0;
  endtask : main_pulse

  task automatic t_reset;
    chk_irq(1'b0);
    rc(6'h0a, 8'h00);
    rc(6'h0b, 8'h00);
    rc(6'h0c, 8'h00);
    rc(6'h0d, 8'h00);
    rc(6'h08, 8'hc0);
    rc(6'h09, 8'h00);
    rc(6'h3f, 8'h00);
  endtask : t_reset

  task automatic t_aux;
    logic [14:0] v[10];
    logic [7:0] e[10];
    v = '{15'h0001, 15'h0002, 15'h0004, 15'h0008, 15'h0090, 15'h00b0, 15'h00d0,
          15'h0180, 15'h0010, 15'h0100};
    e = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h02, 8'h01, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++) begin
      pulse(v[i]);
      chk_irq(e[i] != 8'h00);
      rc(6'h0a, {7'h00, e[i] != 8'h00});
      rc(6'h0a, {7'h00, e[i] != 8'h00});
      rc(6'h0b, e[i]);
      rc(6'h0b, 8'h00);
      rc(6'h0a, 8'h00);
      chk_irq(1'b0);
    end
  endtask : t_aux

  task automatic t_main;
    main_pulse(7'h04);
    pulse(15'h0001);
    chk_irq(1'b1);
    rc(6'h0a, 8'h09);
    rc(6'h0a, 8'h01);
    rc(6'h0b, 8'h80);
    rc(6'h0a, 8'h00);
    u_host.wr(6'h08, 8'h08);
    u_host.wr(6'h09, 8'h80);
    main_pulse(7'h04);
    pulse(15'h0001);
    chk_irq(1'b0);
    rc(6'h09, 8'h80);
    pulse(15'h0004);
    chk_irq(1'b1);
    pulse(15'h4000);
    chk_irq(1'b0);
    rc(6'h0a, 8'h00);
    rc(6'h0b, 8'h00);
    rc(6'h08, 8'hc0);
    rc(6'h09, 8'h00);
    u_host.wr(6'h08, 8'h01);
    rc(6'h08, 8'h00);
    u_host.wr(6'h0b, 8'hff);
    rc(6'h0b, 8'h00);
  endtask : t_main

  task automatic t_fifo;
    repeat (32) pulse(15'h0200);
    rc(6'h0c, 8'h20);
    pulse(15'h0200);
    rc(6'h0c, 8'h20);
    rc(6'h0d, 8'h20);
    rc(6'h0b, 8'h08);
    repeat (32) pulse(15'h0400);
    rc(6'h0c, 8'h00);
    pulse(15'h0400);
    rc(6'h0c, 8'h00);
    rc(6'h0d, 8'h60);
    rc(6'h0b, 8'h08);
    pulse(15'h2000);
    rc(6'h0c, 8'h00);
    pulse(15'h0204);
    rc(6'h0c, 8'h01);
    rc(6'h0b, 8'h20);
    pulse(15'h0600);
    rc(6'h0c, 8'h01);
    rc(6'h0d, 8'h00);
    @(negedge clk) last_bits = 3'h5;
    pulse(15'h0800);
    rc(6'h0d, 8'h1a);
    @(negedge clk) last_bits = 3'h0;
    pulse(15'h1800);
    rc(6'h0d, 8'h01);
    rc(6'h0b, 8'h40);
    pulse(15'h2000);
    rc(6'h0c, 8'h00);
  endtask : t_fifo

  // A stuck sequence still ends in the closing report
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    t_reset();
    t_aux();
    t_main();
    t_fifo();
    conclude();
  end
endmodule : irq_and_fifo_status_regs_tb
